// ### core/fls_fault_latch.sv
// Module: fault enable, sticky latch, summary, alert and re-servo requests
`timescale 1ns/1ps
module fls_fault_latch
	import fls_pkg::*;
#(
	parameter int FAULT_COUNT = FLS_FAULT_COUNT
)
(
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  regSel,
	input  wire logic        regWr,
	input  wire logic        regRd,
	input  wire logic [15:0] regWdata,
	output logic      [15:0] regRdata,
	output logic             regRdValid,
	input  wire logic [13:0] instantFault,
	input  wire logic        alertOutputDisable,
	input  wire logic [1:0]  servoEnabled,
	input  wire logic [1:0]  continuousServo,
	input  wire logic [1:0]  monitorSelect,
	output logic             alertN,
	output logic [1:0]       reservoStart
);

	// Fault field must fit below the two re-servo bits
	if (FAULT_COUNT < 1 || FAULT_COUNT > FLS_FAULT_COUNT) begin : g_chk
		$error("FAULT_COUNT out of range");
	end

	logic [15:0] enableQ;
	logic [15:0] enableD;
	logic [13:0] flagsQ;
	logic [13:0] flagsD;
	logic [13:0] setVec;
	logic [15:0] rdataQ;
	logic        rdValidQ;
	logic        alertNQ;
	logic        enWr;
	logic        rdFlags;
	logic        rdSummary;
	logic        anyLatched;

	fls_servo_if srv ();

	////////////////////////////////////////////////////////////////////
	// Decode
	function automatic logic hit(input logic [7:0] sel,
		input logic [7:0] code);
		return sel == code;
	endfunction

	assign enWr      = regWr && hit(regSel, FLS_CMD_ENABLE);
	assign rdFlags   = regRd && hit(regSel, FLS_CMD_FLAGS);
	assign rdSummary = regRd && hit(regSel, FLS_CMD_SUMMARY);

	// New enable takes effect in the same edge as the latch update
	assign enableD = enWr ? regWdata : enableQ;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			enableQ <= FLS_ENABLE_RESET;
		end else begin
			enableQ <= enableD;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Latch
	// enabled faults set
	assign setVec = instantFault & enableD[13:0];

	// Writes to summary or flags never touch this logic
	always_comb begin
		flagsD = flagsQ;
		if (rdFlags) begin
			flagsD = '0;
		end
		flagsD = flagsD | setVec;
		flagsD = flagsD & enableD[13:0];
		if (FAULT_COUNT < FLS_FAULT_COUNT) begin
			flagsD = flagsD & ((14'h0001 << FAULT_COUNT) - 14'h0001);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			flagsQ <= FLS_FLAGS_RESET[13:0];
		end else begin
			flagsQ <= flagsD;
		end
	end

	assign anyLatched = |flagsQ;

	////////////////////////////////////////////////////////////////////
	// Read path: data is the value before any clear of this cycle
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rdataQ <= FLS_RDATA_RESET;
		end else if (regRd) begin
			unique case (regSel)
				FLS_CMD_ENABLE:  rdataQ <= enableQ;
				FLS_CMD_SUMMARY: rdataQ <= {15'h0000, anyLatched};
				FLS_CMD_FLAGS:   rdataQ <= {2'h0, flagsQ};
				default:         rdataQ <= 16'h0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rdValidQ <= 1'b0;
		end else begin
			rdValidQ <= regRd;
		end
	end

	assign regRdata   = rdataQ;
	assign regRdValid = rdValidQ;

	////////////////////////////////////////////////////////////////////
	// Alert, registered so the pin cannot glitch
	// alert gating
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			alertNQ <= 1'b1;
		end else begin
			alertNQ <= !(anyLatched && !alertOutputDisable);
		end
	end

	assign alertN = alertNQ;

	////////////////////////////////////////////////////////////////////
	// Re-servo requests
	assign srv.armEnable  = {enableQ[FLS_RESERVO_S1A_BIT],
		enableQ[FLS_RESERVO_S0A_BIT]};
	assign srv.overUnder  = {
		instantFault[FLS_OVER_S1A_BIT] | instantFault[FLS_UNDER_S1A_BIT],
		instantFault[FLS_OVER_S0A_BIT] | instantFault[FLS_UNDER_S0A_BIT]};
	assign srv.servoOn    = servoEnabled;
	assign srv.continuous = continuousServo;
	assign srv.monitor    = monitorSelect;
	assign reservoStart   = srv.start;

	fls_reservo u_reservo (
		.sys_clk (sys_clk),
		.rst     (rst),
		.srv     (srv.unit)
	);

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	property p_masked_zero;
		(flagsQ & ~enableQ[13:0]) == 14'h0000;
	endproperty
	a_masked_zero: assert property (p_masked_zero)
		else $error("latched bit set while disabled");

	property p_set;
		(|setVec) |=> (flagsQ & $past(setVec)) == $past(setVec);
	endproperty
	a_set: assert property (p_set)
		else $error("enabled fault not latched");

	property p_sticky;
		(!rdFlags && !enWr) |=> (flagsQ & $past(flagsQ)) == $past(flagsQ);
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("latched bit dropped without clear");

	property p_summary;
		rdSummary |=> regRdValid && regRdata == {15'h0000, $past(anyLatched)};
	endproperty
	a_summary: assert property (p_summary)
		else $error("summary read data wrong");

	property p_summary_keep;
		(rdSummary && !enWr) |=> (flagsQ & $past(flagsQ)) == $past(flagsQ);
	endproperty
	a_summary_keep: assert property (p_summary_keep)
		else $error("summary read cleared flags");

	property p_en_clear;
		enWr |=> (flagsQ & ~$past(regWdata[13:0])) == 14'h0000;
	endproperty
	a_en_clear: assert property (p_en_clear)
		else $error("disable write left flag set");

	property p_read_clear;
		(rdFlags && !enWr) |=> flagsQ == $past(setVec);
	endproperty
	a_read_clear: assert property (p_read_clear)
		else $error("flags read did not clear");

	property p_read_data;
		rdFlags |=> regRdata == {2'h0, $past(flagsQ)};
	endproperty
	a_read_data: assert property (p_read_data)
		else $error("flags read data not pre-clear value");

	property p_alert;
		(anyLatched && !alertOutputDisable) |=> !alertN;
	endproperty
	a_alert: assert property (p_alert)
		else $error("alert not asserted");

	property p_alert_off;
		alertOutputDisable |=> alertN;
	endproperty
	a_alert_off: assert property (p_alert_off)
		else $error("alert asserted while disabled");

	property p_ro_write;
		(regWr && !regRd && setVec == 14'h0000
			&& (hit(regSel, FLS_CMD_FLAGS) || hit(regSel, FLS_CMD_SUMMARY)))
			|=> flagsQ == $past(flagsQ);
	endproperty
	a_ro_write: assert property (p_ro_write)
		else $error("write to read-only register changed flags");

	c_latch: cover property (rdFlags && anyLatched);
	c_race: cover property (rdFlags && (|setVec));
	c_alert: cover property ($fell(alertN));
	c_reservo: cover property (reservoStart[1]);

endmodule // fls_fault_latch

// ### core/fls_pkg.sv
// Package: command codes, field positions and reset values of the fault latch
package fls_pkg;

	// Command codes of the three registers
	localparam logic [7:0]  FLS_CMD_ENABLE      = 8'h10;
	localparam logic [7:0]  FLS_CMD_SUMMARY     = 8'h11;
	localparam logic [7:0]  FLS_CMD_FLAGS       = 8'h12;

	// Register geometry and field positions
	localparam int          FLS_REG_WIDTH       = 16;
	localparam int          FLS_FAULT_COUNT     = 14;
	localparam int          FLS_RESERVO_S0A_BIT = 14;
	localparam int          FLS_RESERVO_S1A_BIT = 15;
	localparam int          FLS_OVER_S0A_BIT    = 0;
	localparam int          FLS_UNDER_S0A_BIT   = 1;
	localparam int          FLS_OVER_S1A_BIT    = 5;
	localparam int          FLS_UNDER_S1A_BIT   = 6;
	localparam int          FLS_SUMMARY_BIT     = 0;

	// Reset values
	localparam logic [15:0] FLS_ENABLE_RESET    = 16'h0000;
	localparam logic [15:0] FLS_FLAGS_RESET     = 16'h0000;
	localparam logic [15:0] FLS_RDATA_RESET     = 16'h0000;

endpackage

// ### core/fls_reservo.sv
// Module: one-shot re-servo trigger for sense channels 0a and 1a
`timescale 1ns/1ps
module fls_reservo
	import fls_pkg::*;
(
	input  wire logic    sys_clk,
	input  wire logic    rst,
	fls_servo_if.unit    srv
);

	logic [1:0] trigger;
	logic [1:0] prevQ;
	logic [1:0] startQ;

	// Qualified trigger; continuous servo already repeats, so skip it
	// three preconditions checked
	assign trigger = srv.armEnable & srv.overUnder & srv.servoOn
		& ~srv.continuous & srv.monitor;

	// Edge memory so a standing fault starts one servo only
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			prevQ <= 2'h0;
		end else begin
			prevQ <= trigger;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			startQ <= 2'h0;
		end else begin
			startQ <= trigger & ~prevQ;
		end
	end

	assign srv.start = startQ;

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	property p_start_s0a;
		srv.start[0] |-> $past(srv.armEnable[0]) && $past(srv.overUnder[0]);
	endproperty
	a_start_s0a: assert property (p_start_s0a)
		else $error("channel 0a re-servo without enabled fault");

	property p_cond_s0a;
		srv.start[0] |-> $past(srv.servoOn[0]) && !$past(srv.continuous[0])
			&& $past(srv.monitor[0]);
	endproperty
	a_cond_s0a: assert property (p_cond_s0a)
		else $error("channel 0a re-servo without preconditions");

	property p_fire_s1a;
		(trigger[1] && !prevQ[1]) |=> srv.start[1];
	endproperty
	a_fire_s1a: assert property (p_fire_s1a)
		else $error("channel 1a re-servo missed");

	property p_cond_s1a;
		srv.start[1] |-> $past(srv.armEnable[1]) && $past(srv.servoOn[1])
			&& !$past(srv.continuous[1]) && $past(srv.monitor[1]);
	endproperty
	a_cond_s1a: assert property (p_cond_s1a)
		else $error("channel 1a re-servo without preconditions");

	c_start_s0a: cover property (srv.start[0]);

endmodule // fls_reservo

// ### core/fls_servo_if.sv
// Interface: re-servo request signals between the latch and the trigger unit
`timescale 1ns/1ps
interface fls_servo_if;
	logic [1:0] armEnable;   // Re-servo enable bits, channel 0a and 1a
	logic [1:0] overUnder;   // Instantaneous over or under fault per channel
	logic [1:0] servoOn;     // Servo operation enabled
	logic [1:0] continuous;  // Continuous-repeat servo option
	logic [1:0] monitor;     // Monitoring selected
	logic [1:0] start;       // One-cycle re-servo start

	modport ctrl (
		output armEnable,
		output overUnder,
		output servoOn,
		output continuous,
		output monitor,
		input  start
	);
	modport unit (
		input  armEnable,
		input  overUnder,
		input  servoOn,
		input  continuous,
		input  monitor,
		output start
	);
endinterface

// ### sim/fault_latch_unit_tb.sv
// Testbench: fault enable, sticky latch, summary, alert and re-servo
`timescale 1ns/1ps
module fault_latch_unit_tb;
	import fls_pkg::*;
	logic        sys_clk, rst, regWr, regRd, regRdValid, alertN;
	logic        alertOutputDisable, ok;
	logic [7:0]  regSel;
	logic [15:0] regWdata, regRdata, rdv;
	logic [13:0] instantFault;
	logic [1:0]  servoEnabled, continuousServo, monitorSelect, reservoStart;
	int          n_mismatch, cmp_count, nS0, nS1;

	fls_fault_latch dut_u (.sys_clk(sys_clk), .rst(rst), .regSel(regSel),
		.regWr(regWr), .regRd(regRd), .regWdata(regWdata),
		.regRdata(regRdata), .regRdValid(regRdValid),
		.instantFault(instantFault), .alertOutputDisable(alertOutputDisable),
		.servoEnabled(servoEnabled), .continuousServo(continuousServo),
		.monitorSelect(monitorSelect), .alertN(alertN),
		.reservoStart(reservoStart));
	fls_host_model host_u (.sys_clk(sys_clk), .regRdata(regRdata),
		.regRdValid(regRdValid), .regSel(regSel), .regWr(regWr),
		.regRd(regRd), .regWdata(regWdata));

	// 200 MHz clock
	initial sys_clk = 1'b0;
	always #2.5 sys_clk = ~sys_clk;

	////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// A read that never answers ends the run
	task automatic rdchk(input logic [7:0] code, input logic [15:0] exp);
		host_u.rd(code, rdv, ok);
		if (ok !== 1'b1) begin
			n_mismatch++;
			complete_run();
		end else begin
			chk(rdv, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// Counts re-servo pulses per channel over n cycles
	task automatic count(input int n);
		nS0 = 0;
		nS1 = 0;
		repeat (n) begin
			@(negedge sys_clk);
			if (reservoStart[0] === 1'b1) nS0++;
			if (reservoStart[1] === 1'b1) nS1++;
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rdchk(FLS_CMD_ENABLE, FLS_ENABLE_RESET);
		rdchk(FLS_CMD_FLAGS, FLS_FLAGS_RESET);
		rdchk(FLS_CMD_SUMMARY, 16'h0000);
		rdchk(8'h7f, 16'h0000);
		chk({15'h0000, alertN}, 16'h0001);
		$display("test reset done");
	endtask
	task automatic t_latch();
		host_u.wr(FLS_CMD_ENABLE, 16'he001);
		instantFault = 14'h3fff;
		cyc(2);
		instantFault = 14'h0000;
		rdchk(FLS_CMD_SUMMARY, 16'h0001);
		rdchk(FLS_CMD_SUMMARY, 16'h0001);
		rdchk(FLS_CMD_FLAGS, 16'h2001);
		rdchk(FLS_CMD_FLAGS, 16'h0000);
		chk({15'h0000, alertN}, 16'h0001);
		$display("test latch done");
	endtask
	task automatic t_alert();
		alertOutputDisable = 1'b0;
		host_u.wr(FLS_CMD_ENABLE, 16'h0003);
		instantFault = 14'h0003;
		cyc(1);
		instantFault = 14'h0000;
		cyc(2);
		chk({15'h0000, alertN}, 16'h0000);
		host_u.wr(FLS_CMD_ENABLE, 16'h0001);
		host_u.wr(FLS_CMD_FLAGS, 16'hffff);
		host_u.wr(FLS_CMD_SUMMARY, 16'hffff);
		rdchk(FLS_CMD_FLAGS, 16'h0001);
		cyc(2);
		chk({15'h0000, alertN}, 16'h0001);
		$display("test alert done");
	endtask
	task automatic t_race();
		host_u.wr(FLS_CMD_ENABLE, 16'h0010);
		instantFault = 14'h0010;
		cyc(1);
		rdchk(FLS_CMD_FLAGS, 16'h0010);
		rdchk(FLS_CMD_FLAGS, 16'h0010);
		instantFault = 14'h0000;
		rdchk(FLS_CMD_FLAGS, 16'h0010);
		rdchk(FLS_CMD_FLAGS, 16'h0000);
		$display("test race done");
	endtask
	task automatic t_reservo();
		servoEnabled = 2'b11;
		continuousServo = 2'b10;
		monitorSelect = 2'b11;
		host_u.wr(FLS_CMD_ENABLE, 16'hc000);
		instantFault = 14'h0041;
		count(8);
		chk(16'(nS0), 16'h0001);
		chk(16'(nS1), 16'h0000);
		instantFault = 14'h0000;
		continuousServo = 2'b00;
		host_u.wr(FLS_CMD_ENABLE, 16'h8000);
		instantFault = 14'h0022;
		count(8);
		chk(16'(nS1), 16'h0001);
		chk(16'(nS0), 16'h0000);
		// Channel 0a lacks monitoring, channel 1a lacks servo
		instantFault = 14'h0000;
		servoEnabled = 2'b01;
		monitorSelect = 2'b10;
		host_u.wr(FLS_CMD_ENABLE, 16'hc000);
		instantFault = 14'h0063;
		count(8);
		chk(16'(nS0), 16'h0000);
		chk(16'(nS1), 16'h0000);
		$display("test reservo done");
	endtask

	// Main sequence
	initial begin
		n_mismatch = 0;
		cmp_count = 0;
		rst = 1'b1;
		instantFault = 14'h0000;
		alertOutputDisable = 1'b1;
		servoEnabled = 2'b00;
		continuousServo = 2'b00;
		monitorSelect = 2'b00;
		cyc(5);
		rst = 1'b0;
		t_reset();
		t_latch();
		t_alert();
		t_race();
		t_reservo();
		complete_run();
	end
endmodule // fault_latch_unit_tb

// ### sim/fls_host_model.sv
// Host model: command register reads and writes on the fault latch
`timescale 1ns/1ps
module fls_host_model (
	input  wire logic        sys_clk,
	input  wire logic [15:0] regRdata,
	input  wire logic        regRdValid,
	output logic      [7:0]  regSel,
	output logic             regWr,
	output logic             regRd,
	output logic      [15:0] regWdata
);
	// Idle bus at time zero
	initial begin
		regSel = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
		regWdata = 16'h0000;
	end

	////////////////////////////////////////////////////////////////////////
	// One-cycle write strobe; data is scrambled after release
	task automatic wr(input logic [7:0] code, input logic [15:0] data);
		@(negedge sys_clk);
		regSel = code;
		regWdata = data;
		regWr = 1'b1;
		@(negedge sys_clk);
		regWr = 1'b0;
		regWdata = ~data;
	endtask

	// One-cycle read strobe; answer picked up under a bound
	task automatic rd(input logic [7:0] code, output logic [15:0] data,
		output logic ok);
		int n;
		@(negedge sys_clk);
		regSel = code;
		regRd = 1'b1;
		@(negedge sys_clk);
		regRd = 1'b0;
		ok = 1'b0;
		data = 16'hffff;
		n = 0;
		while (!ok && n < 4) begin
			if (regRdValid === 1'b1) begin
				ok = 1'b1;
				data = regRdata;
			end else begin
				@(negedge sys_clk);
				n++;
			end
		end
	endtask
endmodule // fls_host_model
